/* File: rtl/ewdt_pkg.sv */
// Constants, types and helpers shared by the watchdog block.
package ewdt_pkg;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam int             ADDR_W        = 8;
   localparam logic [7:0]     CTRL_OFFSET   = 8'h00;
   localparam logic [7:0]     CAUSE_OFFSET  = 8'h04;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int             FLAG_BIT      = 7;
   localparam int             IE_BIT        = 6;
   localparam int             PSEL_HI_BIT   = 5;
   localparam int             UNLOCK_BIT    = 4;
   localparam int             RE_BIT        = 3;
   localparam int             CAUSE_BIT     = 3;

   // ==========================================================================
   // Reset values and counts
   // ==========================================================================
   localparam logic [3:0]     PERIOD_RESET  = 4'h0;
   localparam logic [2:0]     UNLOCK_CYCLES = 3'h4;
   localparam logic [3:0]     PERIOD_MAX    = 4'h9;
   localparam logic [20:0]    BASE_PERIOD   = 21'h000800;
   localparam int             CNT_W         = 20;

   // ==========================================================================
   // Timing
   // ==========================================================================
   localparam int             OSC_FREQ_KHZ  = 128;
   localparam int             PCLK_FREQ_KHZ = 200000;
   localparam int             OSC_HALF_CYC  = PCLK_FREQ_KHZ / (2 * OSC_FREQ_KHZ);

   // ==========================================================================
   // Operating modes
   // ==========================================================================
   typedef enum logic [3:0] {
      MODE_STOPPED = 4'b0001,
      MODE_IRQ     = 4'b0010,
      MODE_RESET   = 4'b0100,
      MODE_IRQ_RST = 4'b1000
   } ewdt_mode_t;

   // Last count value of a period; reserved codes fall back to the longest.
   function automatic logic [CNT_W-1:0] ewdt_period_last(input logic [3:0] code);
      logic [3:0]  sel;
      logic [20:0] len;
      sel = (code > PERIOD_MAX) ? PERIOD_MAX : code;
      len = BASE_PERIOD << sel;
      return len[CNT_W-1:0] - 20'h00001;
   endfunction : ewdt_period_last

endpackage : ewdt_pkg

/* File: rtl/ewdt_sync.sv */
// Two flip-flop synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
module ewdt_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] q_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= '0;
         q_r    <= '0;
      end
      else
      begin
         meta_r <= d;
         q_r    <= meta_r;
      end
   end

   assign q = q_r;

endmodule : ewdt_sync

/* File: rtl/ewdt_counter.sv */
// Time-out counter stepped by oscillator ticks.
`timescale 1ns/1ps
module ewdt_counter #(
   parameter int CW = ewdt_pkg::CNT_W
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       osc_tick,
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [3:0] period_sel,
   output logic            timeout
);
   import ewdt_pkg::*;

   logic [CW-1:0] count_r;
   logic [CW-1:0] count_nxt;
   logic          timeout_r;
   logic          timeout_nxt;
   logic [CW-1:0] last;

   always_comb
   begin
      last        = CW'(ewdt_period_last(period_sel));
      count_nxt   = count_r;
      timeout_nxt = 1'b0;
      if (!run || restart)
         count_nxt = '0;
      else if (osc_tick)
      begin
         // A shorter period than the current count expires at the next tick.
         if (count_r >= last)
         begin
            count_nxt   = '0;
            timeout_nxt = 1'b1;
         end
         else
            count_nxt = count_r + CW'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_r   <= '0;
         timeout_r <= 1'b0;
      end
      else
      begin
         count_r   <= count_nxt;
         timeout_r <= timeout_nxt;
      end
   end

   assign timeout = timeout_r;

endmodule : ewdt_counter

/* File: rtl/ewdt_top.sv */
// Watchdog timer with APB register access, time-out interrupt and reset pulse.
`timescale 1ns/1ps
module ewdt_top (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic [ewdt_pkg::ADDR_W-1:0] paddr,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic                        wdt_osc_clk,
   input  wire logic                        always_on_fuse,
   input  wire logic                        restart_cmd,
   input  wire logic                        irq_vector_ack,
   input  wire logic                        global_irq_enable,
   output logic                             timeout_irq_req,
   output logic                             sys_reset_pulse
);
   import ewdt_pkg::*;

   // ==========================================================================
   // Declarations
   // ==========================================================================
   logic        flag_r,       flag_nxt;
   logic        ie_r,         ie_nxt;
   logic        re_r,         re_nxt;
   logic        unlock_r,     unlock_nxt;
   logic [2:0]  unlock_cnt_r, unlock_cnt_nxt;
   logic [3:0]  period_r,     period_nxt;
   logic        cause_r,      cause_nxt;
   logic        rst_r,        rst_nxt;
   logic        irq_r,        irq_nxt;
   logic        osc_d_r;
   logic        pready_r,     pready_nxt;
   logic        pslverr_r,    pslverr_nxt;
   logic [31:0] prdata_r,     prdata_nxt;

   logic        osc_s;
   logic        fuse_s;
   logic        osc_tick;
   logic        timeout;
   logic        fuse_prog;
   logic        re_eff;
   logic        ie_eff;
   ewdt_mode_t  mode;
   logic        run;
   logic        addr_ctrl;
   logic        addr_cause;
   logic        apb_done;
   logic        wr_ctrl;
   logic        wr_cause;
   logic [7:0]  ctrl_rd;

   // ==========================================================================
   // Synchronisers and counter
   // ==========================================================================
   ewdt_sync #(
      .WIDTH (2)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({wdt_osc_clk, always_on_fuse}),
      .q       ({osc_s, fuse_s})
   );

   ewdt_counter #(
      .CW (CNT_W)
   ) u_counter (
      .pclk       (pclk),
      .presetn    (presetn),
      .osc_tick   (osc_tick),
      .run        (run),
      .restart    (restart_cmd),
      .period_sel (period_r),
      .timeout    (timeout)
   );

   function automatic ewdt_mode_t mode_decode(input logic re, input logic ie);
      unique case ({re, ie})
         2'b00:   return MODE_STOPPED;
         2'b01:   return MODE_IRQ;
         2'b10:   return MODE_RESET;
         2'b11:   return MODE_IRQ_RST;
      endcase
   endfunction : mode_decode

   // ==========================================================================
   // Mode and decode
   // ==========================================================================
   always_comb
   begin
      osc_tick   = osc_s & ~osc_d_r;
      fuse_prog  = ~fuse_s;
      re_eff     = fuse_prog | re_r | cause_r;
      ie_eff     = ~fuse_prog & ie_r;
      mode       = mode_decode(re_eff, ie_eff);
      run        = (mode != MODE_STOPPED);
      addr_ctrl  = (paddr == CTRL_OFFSET);
      addr_cause = (paddr == CAUSE_OFFSET);
      apb_done   = psel & penable & pready_r;
      wr_ctrl    = apb_done & pwrite & addr_ctrl;
      wr_cause   = apb_done & pwrite & addr_cause;
      ctrl_rd    = {flag_r, ie_eff, period_r[3], unlock_r, re_eff, period_r[2:0]};
   end

   // ==========================================================================
   // Control state
   // ==========================================================================
   always_comb
   begin
      flag_nxt       = flag_r;
      ie_nxt         = ie_r;
      re_nxt         = re_r;
      unlock_nxt     = unlock_r;
      unlock_cnt_nxt = unlock_cnt_r;
      period_nxt     = period_r;
      cause_nxt      = cause_r;
      rst_nxt        = 1'b0;
      if (unlock_r)
      begin
         unlock_cnt_nxt = unlock_cnt_r - 3'h1;
         if (unlock_cnt_r == 3'h1)
            unlock_nxt = 1'b0;
      end
      if (wr_ctrl)
      begin
         if (pwdata[FLAG_BIT])
            flag_nxt = 1'b0;
         ie_nxt         = pwdata[IE_BIT];
         unlock_nxt     = pwdata[UNLOCK_BIT];
         unlock_cnt_nxt = UNLOCK_CYCLES;
         if (pwdata[RE_BIT])
            re_nxt = 1'b1;
         else if (unlock_r && !cause_r)
            re_nxt = 1'b0;
         if (unlock_r)
            period_nxt = {pwdata[PSEL_HI_BIT], pwdata[2:0]};
      end
      if (irq_vector_ack)
      begin
         flag_nxt = 1'b0;
         if (re_eff)
            ie_nxt = 1'b0;
      end
      if (wr_cause && !pwdata[CAUSE_BIT])
         cause_nxt = 1'b0;
      if (timeout)
      begin
         unique case (mode)
            MODE_IRQ:     flag_nxt = 1'b1;
            MODE_RESET:   rst_nxt  = 1'b1;
            MODE_IRQ_RST:
            begin
               if (flag_r)
                  rst_nxt = 1'b1;
               else
                  flag_nxt = 1'b1;
            end
            MODE_STOPPED: rst_nxt  = 1'b0;
         endcase
      end
      // The block itself is not cleared by its own pulse, so the enable survives.
      if (rst_nxt)
         cause_nxt = 1'b1;
      irq_nxt = flag_r & ie_eff & global_irq_enable;
   end

   // ==========================================================================
   // APB slave, one wait state per access
   // ==========================================================================
   always_comb
   begin
      pready_nxt  = psel & penable & ~pready_r;
      prdata_nxt  = 32'h00000000;
      pslverr_nxt = 1'b0;
      if (pready_nxt)
      begin
         pslverr_nxt = ~(addr_ctrl | addr_cause);
         if (addr_ctrl)
            prdata_nxt = {24'h000000, ctrl_rd};
         else if (addr_cause)
            prdata_nxt = 32'(cause_r) << CAUSE_BIT;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_r       <= 1'b0;
         ie_r         <= 1'b0;
         re_r         <= 1'b0;
         unlock_r     <= 1'b0;
         unlock_cnt_r <= 3'h0;
         period_r     <= PERIOD_RESET;
         cause_r      <= 1'b0;
         rst_r        <= 1'b0;
         irq_r        <= 1'b0;
         osc_d_r      <= 1'b0;
         pready_r     <= 1'b0;
         pslverr_r    <= 1'b0;
         prdata_r     <= 32'h00000000;
      end
      else
      begin
         flag_r       <= flag_nxt;
         ie_r         <= ie_nxt;
         re_r         <= re_nxt;
         unlock_r     <= unlock_nxt;
         unlock_cnt_r <= unlock_cnt_nxt;
         period_r     <= period_nxt;
         cause_r      <= cause_nxt;
         rst_r        <= rst_nxt;
         irq_r        <= irq_nxt;
         osc_d_r      <= osc_s;
         pready_r     <= pready_nxt;
         pslverr_r    <= pslverr_nxt;
         prdata_r     <= prdata_nxt;
      end
   end

   assign prdata          = prdata_r;
   assign pready          = pready_r;
   assign pslverr         = pslverr_r;
   assign timeout_irq_req = irq_r;
   assign sys_reset_pulse = rst_r;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_unlock_quiet;
      !wr_ctrl [*4];
   endsequence

   sequence s_pulse_once;
      sys_reset_pulse ##1 !sys_reset_pulse;
   endsequence

   property p_flag_set;
      timeout && mode == MODE_IRQ |=> flag_r && !sys_reset_pulse;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("time-out in interrupt mode did not set the flag");

   property p_ack_clear;
      irq_vector_ack && !timeout |=> !flag_r;
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("vector acknowledge did not clear the flag");

   property p_w1c;
      wr_ctrl && pwdata[FLAG_BIT] && !timeout |=> !flag_r;
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("writing one did not clear the flag");

   property p_irq_req;
      ##1 timeout_irq_req == $past(flag_r && ie_eff && global_irq_enable);
   endproperty
   a_irq_req: assert property (p_irq_req)
      else $error("interrupt request does not follow its enables");

   property p_combined_first;
      timeout && mode == MODE_IRQ_RST && !flag_r |=> flag_r && !sys_reset_pulse;
   endproperty
   a_combined_first: assert property (p_combined_first)
      else $error("first combined time-out misbehaved");

   property p_combined_second;
      timeout && mode == MODE_IRQ_RST && flag_r |=> s_pulse_once;
   endproperty
   a_combined_second: assert property (p_combined_second)
      else $error("unserved combined time-out did not reset");

   property p_fuse_forces;
      fuse_prog |-> mode == MODE_RESET;
   endproperty
   a_fuse_forces: assert property (p_fuse_forces)
      else $error("programmed fuse did not force reset mode");

   property p_period_locked;
      wr_ctrl && !unlock_r |=> $stable(period_r);
   endproperty
   a_period_locked: assert property (p_period_locked)
      else $error("period changed without unlock");

   property p_unlock_expire;
      $rose(unlock_r) ##0 s_unlock_quiet |=> !unlock_r;
   endproperty
   a_unlock_expire: assert property (p_unlock_expire)
      else $error("unlock did not expire after four cycles");

   property p_cause_holds_re;
      cause_r |-> re_eff && ctrl_rd[RE_BIT];
   endproperty
   a_cause_holds_re: assert property (p_cause_holds_re)
      else $error("reset enable not forced by cause flag");

   property p_reset_pulse;
      $rose(sys_reset_pulse) |-> !$past(sys_reset_pulse) ##1 (!sys_reset_pulse && cause_r);
   endproperty
   a_reset_pulse: assert property (p_reset_pulse)
      else $error("reset pulse longer than one cycle or cause not set");

endmodule : ewdt_top

/* File: verif/ewdt_core_model.sv */
// Model of the processor core that restarts the watchdog and serves its vector.
`timescale 1ns/1ps
module ewdt_core_model (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic irq_req,
   output logic      restart_cmd,
   output logic      irq_vector_ack,
   output logic      global_irq_enable
);
   initial
   begin
      restart_cmd       = 1'b0;
      irq_vector_ack    = 1'b0;
      global_irq_enable = 1'b0;
   end

   // Callers enter just after a rising edge.
   task automatic restart();
      restart_cmd <= 1'b1;
      @(posedge pclk);
      restart_cmd <= 1'b0;
   endtask : restart

   // The vector is taken only while the request stands, after lag cycles.
   task automatic serve(input int lag);
      repeat (lag) @(posedge pclk);
      while (irq_req !== 1'b1)
         @(posedge pclk);
      irq_vector_ack <= 1'b1;
      @(posedge pclk);
      irq_vector_ack <= 1'b0;
   endtask : serve

   task automatic set_gie(input logic v);
      global_irq_enable <= v;
   endtask : set_gie
endmodule : ewdt_core_model

/* File: verif/tb.sv */
// Self-checking bench for the watchdog block.
`timescale 1ns/1ps
module tb;
   import ewdt_pkg::*;

   logic              pclk;
   logic              presetn;
   logic [ADDR_W-1:0] paddr;
   logic              psel;
   logic              penable;
   logic              pwrite;
   logic [31:0]       pwdata;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic              wdt_osc_clk;
   logic              always_on_fuse;
   logic              restart_cmd;
   logic              irq_vector_ack;
   logic              global_irq_enable;
   logic              timeout_irq_req;
   logic              sys_reset_pulse;
   int                miscompares = 0;
   int                n_compared  = 0;
   int                cycles      = 0;
   int                ticks       = 0;
   int                n_rst       = 0;
   int                t0;
   logic [31:0]       seed;
   logic [31:0]       rd;
   logic              err;

   ewdt_top ewdt_top_i (
      .pclk(pclk),
      .presetn(presetn),
      .paddr(paddr),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .wdt_osc_clk(wdt_osc_clk),
      .always_on_fuse(always_on_fuse),
      .restart_cmd(restart_cmd),
      .irq_vector_ack(irq_vector_ack),
      .global_irq_enable(global_irq_enable),
      .timeout_irq_req(timeout_irq_req),
      .sys_reset_pulse(sys_reset_pulse)
   );

   ewdt_core_model ewdt_core_model_i (
      .pclk(pclk),
      .presetn(presetn),
      .irq_req(timeout_irq_req),
      .restart_cmd(restart_cmd),
      .irq_vector_ack(irq_vector_ack),
      .global_irq_enable(global_irq_enable)
   );

   // ==========================================================================
   // Clocks and monitors
   // ==========================================================================
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // Shortened oscillator, unrelated in phase to the bus clock.
   initial
   begin
      wdt_osc_clk = 1'b0;
      forever #13 wdt_osc_clk = ~wdt_osc_clk;
   end

   always @(posedge wdt_osc_clk) ticks <= ticks + 1;

   // Five time-outs of about 10650 cycles each fit well under the ceiling.
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (sys_reset_pulse === 1'b1)
         n_rst <= n_rst + 1;
      if (cycles == 100000)
      begin
         miscompares++;
         summarize();
      end
   end

   // ==========================================================================
   // Helpers
   // ==========================================================================
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift

   function automatic logic [7:0] ctrl_val(input logic [3:0] code);
      return {2'b00, code[3], 2'b00, code[2:0]};
   endfunction : ctrl_val

   function automatic logic near(input int n, input logic [3:0] code);
      int p;
      p = 2048 << ((code > 4'h9) ? 4'h9 : code);
      return (n >= p - 1) && (n <= p + 1);
   endfunction : near

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer; with hold set the next setup follows at once.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic hold);
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= wr;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Sampled at the rising edge, before that edge's own updates land.
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      penable <= 1'b0;
      if (!hold)
      begin
         psel <= 1'b0;
         // One idle edge, so a following call never reassigns psel at once.
         @(posedge pclk);
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00, 1'b0);
      check(rd, {24'h000000, exp});
      check(err, 1'b0);
   endtask : rchk

   task automatic unlock_set(input logic [7:0] d);
      apb(1'b1, CTRL_OFFSET, 8'h18, 1'b1);
      apb(1'b1, CTRL_OFFSET, d, 1'b0);
   endtask : unlock_set

   task automatic wait_ev(input logic rst_ev);
      do
         @(posedge pclk);
      while ((rst_ev ? sys_reset_pulse : timeout_irq_req) !== 1'b1);
   endtask : wait_ev

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      paddr = '0;
      pwrite = 1'b0;
      pwdata = '0;
      always_on_fuse = 1'b1;
      seed = 32'h00008acb;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rchk(CTRL_OFFSET, 8'h00);
      rchk(CAUSE_OFFSET, 8'h00);
      wr(8'h08, 8'h25);
      check(err, 1'b1);
      rchk(CTRL_OFFSET, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         seed = xorshift(seed);
         unlock_set(ctrl_val(seed[3:0]));
         rchk(CTRL_OFFSET, ctrl_val(seed[3:0]));
         wr(CTRL_OFFSET, seed[15:8] & 8'ha7);
         rchk(CTRL_OFFSET, ctrl_val(seed[3:0]));
      end
      wr(CTRL_OFFSET, 8'h10);
      rchk(CTRL_OFFSET, ctrl_val(seed[3:0]) | 8'h10);
      repeat (5) @(posedge pclk);
      wr(CTRL_OFFSET, ~ctrl_val(seed[3:0]) & 8'h27);
      rchk(CTRL_OFFSET, ctrl_val(seed[3:0]));
      unlock_set(8'h00);
      $display("test config done");

      ewdt_core_model_i.set_gie(1'b1);
      wr(CTRL_OFFSET, 8'h40);
      ewdt_core_model_i.restart();
      repeat (600) @(posedge pclk);
      ewdt_core_model_i.restart();
      t0 = ticks;
      wait_ev(1'b0);
      check(near(ticks - t0, 4'h0), 1'b1);
      rchk(CTRL_OFFSET, 8'hc0);
      ewdt_core_model_i.set_gie(1'b0);
      repeat (2) @(posedge pclk);
      check(timeout_irq_req, 1'b0);
      wr(CTRL_OFFSET, 8'h40);
      rchk(CTRL_OFFSET, 8'hc0);
      wr(CTRL_OFFSET, 8'hc0);
      rchk(CTRL_OFFSET, 8'h40);
      ewdt_core_model_i.set_gie(1'b1);
      wait_ev(1'b0);
      ewdt_core_model_i.serve(3);
      rchk(CTRL_OFFSET, 8'h40);
      check(n_rst, 0);
      wr(CTRL_OFFSET, 8'h00);
      $display("test irq_mode done");

      wr(CTRL_OFFSET, 8'h48);
      ewdt_core_model_i.restart();
      wait_ev(1'b0);
      t0 = ticks;
      rchk(CTRL_OFFSET, 8'hc8);
      check(n_rst, 0);
      wait_ev(1'b1);
      check(near(ticks - t0, 4'h0), 1'b1);
      @(posedge pclk);
      check(sys_reset_pulse, 1'b0);
      check(n_rst, 1);
      rchk(CAUSE_OFFSET, 8'h08);
      rchk(CTRL_OFFSET, 8'hc8);
      ewdt_core_model_i.serve(0);
      rchk(CTRL_OFFSET, 8'h08);
      unlock_set(8'h00);
      rchk(CTRL_OFFSET, 8'h08);
      wr(CAUSE_OFFSET, 8'h00);
      rchk(CAUSE_OFFSET, 8'h00);
      unlock_set(8'h00);
      rchk(CTRL_OFFSET, 8'h00);
      $display("test combined_mode done");

      always_on_fuse <= 1'b0;
      wr(CTRL_OFFSET, 8'h40);
      rchk(CTRL_OFFSET, 8'h08);
      ewdt_core_model_i.restart();
      t0 = ticks;
      wait_ev(1'b1);
      check(near(ticks - t0, 4'h0), 1'b1);
      rchk(CAUSE_OFFSET, 8'h08);
      check(timeout_irq_req, 1'b0);
      check(n_rst, 2);
      $display("test fuse done");
      summarize();
   end
endmodule : tb
